// ---- acc_control.sv ----
// analog comparator control: input select, result sync, event flag, trigger select
// Functional notes
// - mux enable with converter off routes ADC pin 0-7 to negative input.
// - result bit is comparator output through a 1-2 cycle synchroniser.
// - mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// - flag set on selected event; cleared by vector taken or write one.
// - request only while flag, enable and global enable are all set.
// - power-off bit switches comparator off whenever written one.
// - bandgap select replaces positive input with reference.
// - capture enable routes result to timer capture front end.
// - trigger field picks auto-trigger source only while auto-trigger enabled.
// - conversion starts on rising edge of selected flag, not level.
// - switching from a cleared source to a set source counts as a rising edge.
// - switching to free running never produces a trigger.
// - buffer-off bits disable pin input buffer and force pin read zero.
// - control register at data offset 0x50 and I/O address 0x30.
`timescale 1ns/10ps
module acc_control (
  input wire logic clock,
  input wire logic rst_n,
  // data-space register port
  input wire logic [7:0] dataAddr,
  input wire logic dataWrite,
  input wire logic dataRead,
  input wire logic [7:0] dataWdata,
  // short I/O register port
  input wire logic [5:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  output logic [7:0] readData,
  // analog and system side
  input wire logic compareRaw,
  input wire logic converterEnable,
  input wire logic autoTriggerEnable,
  input wire logic [2:0] channelSelect,
  input wire logic globalIrqEnable,
  input wire logic vectorTaken,
  input wire logic conversionDoneFlag,
  input wire logic extInt0Flag,
  input wire logic t0CompareAFlag,
  input wire logic t0OverflowFlag,
  input wire logic t1CompareBFlag,
  input wire logic t1OverflowFlag,
  input wire logic t1CaptureFlag,
  input wire logic positivePinRaw,
  input wire logic negativePinRaw,
  output logic compareIrq,
  output logic comparatorPowerOff,
  output logic bandgapPositiveSelect,
  output logic negativeFromMux,
  output logic [2:0] negativeMuxChannel,
  output logic captureInput,
  output logic captureRouteEnable,
  output logic autoTriggerStart,
  output logic positivePinBufferOn,
  output logic negativePinBufferOn,
  output logic positivePinRead,
  output logic negativePinRead
);
  logic powerOff_r;
  logic bandgap_r;
  logic eventFlag_r;
  logic irqEnable_r;
  logic captureEn_r;
  logic [1:0] eventMode_r;
  logic muxEnable_r;
  logic [2:0] trigSource_r;
  logic posBufOff_r;
  logic negBufOff_r;
  logic resultSync;
  logic resultPrev_r;
  logic trigLevel;
  logic trigLevelPrev_r;
  logic compareEvent;
  logic ctrlWrite;
  logic ctrlRead;
  logic [7:0] ctrlWdata;
  logic wrConvB;
  logic wrPinDis;
  logic rdConvB;
  logic rdPinDis;
  logic [7:0] ctrlValue;

  // both windows reach the same register; I/O address plus offset gives data address
  always_comb begin
    ctrlWrite = 1'b0;
    ctrlRead = 1'b0;
    ctrlWdata = dataWdata;
    wrConvB = 1'b0;
    wrPinDis = 1'b0;
    rdConvB = 1'b0;
    rdPinDis = 1'b0;
    if (ioWrite && ({2'b00, ioAddr} == acc_pkg::ACC_CTRL_STATUS_IO_ADDR)) begin
      ctrlWrite = 1'b1;
      ctrlWdata = ioWdata;
    end else if (dataWrite && dataAddr == acc_pkg::ACC_CTRL_STATUS_ADDR) begin
      ctrlWrite = 1'b1;
    end else if (dataWrite && dataAddr == acc_pkg::ACC_CONV_STATUS_B_ADDR) begin
      wrConvB = 1'b1;
    end else if (dataWrite && dataAddr == acc_pkg::ACC_PIN_DISABLE_ADDR) begin
      wrPinDis = 1'b1;
    end
    if (ioRead && ({2'b00, ioAddr} == acc_pkg::ACC_CTRL_STATUS_IO_ADDR)) begin
      ctrlRead = 1'b1;
    end else if (dataRead && dataAddr == acc_pkg::ACC_CTRL_STATUS_ADDR) begin
      ctrlRead = 1'b1;
    end else if (dataRead && dataAddr == acc_pkg::ACC_CONV_STATUS_B_ADDR) begin
      rdConvB = 1'b1;
    end else if (dataRead && dataAddr == acc_pkg::ACC_PIN_DISABLE_ADDR) begin
      rdPinDis = 1'b1;
    end
  end

  acc_sync #(.STAGES(acc_pkg::ACC_SYNC_STAGES)) resultSyncInst (
    .clock(clock),
    .rst_n(rst_n),
    .dIn(compareRaw),
    .dOut(resultSync)
  );

  // control bits of comparator_ctrl_status; result bit has no storage here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      powerOff_r <= 1'b0;
      bandgap_r <= 1'b0;
      irqEnable_r <= 1'b0;
      captureEn_r <= 1'b0;
      eventMode_r <= 2'b00;
    end else if (ctrlWrite) begin
      powerOff_r <= ctrlWdata[acc_pkg::ACC_BIT_POWER_OFF];
      bandgap_r <= ctrlWdata[acc_pkg::ACC_BIT_BANDGAP];
      irqEnable_r <= ctrlWdata[acc_pkg::ACC_BIT_IRQ_EN];
      captureEn_r <= ctrlWdata[acc_pkg::ACC_BIT_CAPTURE];
      eventMode_r <= ctrlWdata[acc_pkg::ACC_MODE_MSB -: 2];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      muxEnable_r <= acc_pkg::ACC_CONV_STATUS_B_RESET[acc_pkg::ACC_BIT_MUX_EN];
      trigSource_r <= acc_pkg::ACC_CONV_STATUS_B_RESET[acc_pkg::ACC_TRIG_MSB -: 3];
    end else if (wrConvB) begin
      muxEnable_r <= dataWdata[acc_pkg::ACC_BIT_MUX_EN];
      trigSource_r <= dataWdata[acc_pkg::ACC_TRIG_MSB -: 3];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      posBufOff_r <= acc_pkg::ACC_PIN_DISABLE_RESET[acc_pkg::ACC_BIT_POS_BUF_OFF];
      negBufOff_r <= acc_pkg::ACC_PIN_DISABLE_RESET[acc_pkg::ACC_BIT_NEG_BUF_OFF];
    end else if (wrPinDis) begin
      posBufOff_r <= dataWdata[acc_pkg::ACC_BIT_POS_BUF_OFF];
      negBufOff_r <= dataWdata[acc_pkg::ACC_BIT_NEG_BUF_OFF];
    end
  end

  // event detection on the synchronised result
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resultPrev_r <= 1'b0;
    end else begin
      resultPrev_r <= resultSync;
    end
  end

  // reserved mode raises no event
  always_comb begin
    case (acc_pkg::acc_mode_t'(eventMode_r))
      acc_pkg::ACC_MODE_TOGGLE: compareEvent = resultSync ^ resultPrev_r;
      acc_pkg::ACC_MODE_FALL: compareEvent = resultPrev_r & ~resultSync;
      acc_pkg::ACC_MODE_RISE: compareEvent = ~resultPrev_r & resultSync;
      default: compareEvent = 1'b0;
    endcase
  end

  // set wins over any clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eventFlag_r <= 1'b0;
    end else if (compareEvent) begin
      eventFlag_r <= 1'b1;
    end else if (vectorTaken || (ctrlWrite && ctrlWdata[acc_pkg::ACC_BIT_FLAG])) begin
      eventFlag_r <= 1'b0;
    end
  end

  // trigger level follows the selected source flag
  always_comb begin
    case (acc_pkg::acc_trig_t'(trigSource_r))
      acc_pkg::ACC_TRIG_FREE: trigLevel = 1'b0;
      acc_pkg::ACC_TRIG_COMPARATOR: trigLevel = eventFlag_r;
      acc_pkg::ACC_TRIG_EXT_INT0: trigLevel = extInt0Flag;
      acc_pkg::ACC_TRIG_T0_CMP_A: trigLevel = t0CompareAFlag;
      acc_pkg::ACC_TRIG_T0_OVF: trigLevel = t0OverflowFlag;
      acc_pkg::ACC_TRIG_T1_CMP_B: trigLevel = t1CompareBFlag;
      acc_pkg::ACC_TRIG_T1_OVF: trigLevel = t1OverflowFlag;
      default: trigLevel = t1CaptureFlag;
    endcase
  end

  // free running is retriggered by the converter itself, so its pulse stays low here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trigLevelPrev_r <= 1'b0;
      autoTriggerStart <= 1'b0;
    end else begin
      trigLevelPrev_r <= trigLevel;
      autoTriggerStart <= autoTriggerEnable && converterEnable && trigLevel && !trigLevelPrev_r;
    end
  end

  // outputs toward analog, core and ports, all registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compareIrq <= 1'b0;
      comparatorPowerOff <= 1'b0;
      bandgapPositiveSelect <= 1'b0;
      negativeFromMux <= 1'b0;
      negativeMuxChannel <= 3'h0;
      captureInput <= 1'b0;
      captureRouteEnable <= 1'b0;
      positivePinBufferOn <= 1'b1;
      negativePinBufferOn <= 1'b1;
      positivePinRead <= 1'b0;
      negativePinRead <= 1'b0;
    end else begin
      compareIrq <= eventFlag_r && irqEnable_r && globalIrqEnable;
      comparatorPowerOff <= powerOff_r;
      bandgapPositiveSelect <= bandgap_r;
      negativeFromMux <= muxEnable_r && !converterEnable;
      negativeMuxChannel <= channelSelect;
      captureInput <= captureEn_r && resultSync;
      captureRouteEnable <= captureEn_r;
      positivePinBufferOn <= !posBufOff_r;
      negativePinBufferOn <= !negBufOff_r;
      positivePinRead <= positivePinRaw && !posBufOff_r;
      negativePinRead <= negativePinRaw && !negBufOff_r;
    end
  end

  // result bit taken live from the synchroniser, writes cannot reach it
  always_comb begin
    ctrlValue = {powerOff_r, bandgap_r, resultSync, eventFlag_r, irqEnable_r, captureEn_r, eventMode_r};
  end

  // read data held one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 8'h00;
    end else if (ctrlRead) begin
      readData <= ctrlValue;
    end else if (rdConvB) begin
      readData <= {1'b0, muxEnable_r, 3'b000, trigSource_r};
    end else if (rdPinDis) begin
      readData <= {6'b000000, negBufOff_r, posBufOff_r};
    end else begin
      readData <= 8'h00;
    end
  end
endmodule : acc_control

// ---- acc_pkg.sv ----
// constants for the analog comparator control block
package acc_pkg;
  localparam logic [7:0] ACC_CTRL_STATUS_ADDR = 8'h50;
  localparam logic [7:0] ACC_IO_OFFSET = 8'h20;
  localparam logic [7:0] ACC_CTRL_STATUS_IO_ADDR = 8'h30;
  localparam logic [7:0] ACC_CONV_STATUS_B_ADDR = 8'h7B;
  localparam logic [7:0] ACC_PIN_DISABLE_ADDR = 8'h7F;
  localparam logic [7:0] ACC_CONV_STATUS_B_RESET = 8'h00;
  localparam logic [7:0] ACC_PIN_DISABLE_RESET = 8'h00;
  // comparator_ctrl_status fields
  localparam int ACC_BIT_POWER_OFF = 7;
  localparam int ACC_BIT_BANDGAP = 6;
  localparam int ACC_BIT_RESULT = 5;
  localparam int ACC_BIT_FLAG = 4;
  localparam int ACC_BIT_IRQ_EN = 3;
  localparam int ACC_BIT_CAPTURE = 2;
  localparam int ACC_MODE_MSB = 1;
  // converter_ctrl_status_b fields
  localparam int ACC_BIT_MUX_EN = 6;
  localparam int ACC_TRIG_MSB = 2;
  // pin disable fields
  localparam int ACC_BIT_POS_BUF_OFF = 0;
  localparam int ACC_BIT_NEG_BUF_OFF = 1;
  localparam int ACC_SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RESERVED = 2'b01,
    ACC_MODE_FALL = 2'b10,
    ACC_MODE_RISE = 2'b11
  } acc_mode_t;
  typedef enum logic [2:0] {
    ACC_TRIG_FREE = 3'b000,
    ACC_TRIG_COMPARATOR = 3'b001,
    ACC_TRIG_EXT_INT0 = 3'b010,
    ACC_TRIG_T0_CMP_A = 3'b011,
    ACC_TRIG_T0_OVF = 3'b100,
    ACC_TRIG_T1_CMP_B = 3'b101,
    ACC_TRIG_T1_OVF = 3'b110,
    ACC_TRIG_T1_CAPTURE = 3'b111
  } acc_trig_t;
endpackage : acc_pkg

// ---- acc_sync.sv ----
// two-stage level synchroniser
`timescale 1ns/10ps
module acc_sync #(
  parameter int STAGES = acc_pkg::ACC_SYNC_STAGES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dIn,
  output logic dOut
);
  logic [STAGES-1:0] chain_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[STAGES-2:0], dIn};
    end
  end
  assign dOut = chain_r[STAGES-1];
endmodule : acc_sync

// ---- acc_analog_model.sv ----
// analog front-end stand-in that produces the raw comparator level
`timescale 1ns/10ps
module acc_analog_model #(
  parameter logic [3:0] BG_LEVEL = 4'h6
) (
  input wire logic comparatorPowerOff,
  input wire logic bandgapPositiveSelect,
  input wire logic negativeFromMux,
  input wire logic [3:0] posLevel,
  input wire logic [3:0] negLevel,
  input wire logic [3:0] muxLevel,
  output logic compareRaw
);
  logic [3:0] plusIn;
  logic [3:0] minusIn;
  assign plusIn = bandgapPositiveSelect ? BG_LEVEL : posLevel;
  assign minusIn = negativeFromMux ? muxLevel : negLevel;
  // an unpowered comparator settles low
  assign compareRaw = !comparatorPowerOff && (plusIn > minusIn);
endmodule : acc_analog_model

// ---- acc_control_assertions.sv ----
// port-level checks for the comparator control block
`timescale 1ns/10ps
module acc_control_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dataWrite,
  input wire logic ioWrite,
  input wire logic dataRead,
  input wire logic ioRead,
  input wire logic [7:0] readData,
  input wire logic converterEnable,
  input wire logic autoTriggerEnable,
  input wire logic [2:0] channelSelect,
  input wire logic globalIrqEnable,
  input wire logic compareIrq,
  input wire logic comparatorPowerOff,
  input wire logic negativeFromMux,
  input wire logic [2:0] negativeMuxChannel,
  input wire logic captureInput,
  input wire logic captureRouteEnable,
  input wire logic autoTriggerStart,
  input wire logic positivePinBufferOn,
  input wire logic positivePinRead
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence sQuiet;
    ##1 !autoTriggerStart;
  endsequence
  a_trig_pulse: assert property (autoTriggerStart |-> sQuiet)
    else $error("trigger start longer than one cycle");
  a_trig_gate: assert property (autoTriggerStart |-> $past(autoTriggerEnable) && $past(converterEnable))
    else $error("trigger start while disabled");
  a_irq_gate: assert property (compareIrq |-> $past(globalIrqEnable))
    else $error("request without global enable");
  a_mux_select: assert property (negativeFromMux |-> !$past(converterEnable))
    else $error("mux input while converter on");
  a_mux_channel: assert property (negativeMuxChannel == $past(channelSelect))
    else $error("mux channel not followed");
  a_pin_forced: assert property (!positivePinBufferOn |-> !positivePinRead)
    else $error("disabled pin reads high");
  a_read_idle: assert property (!$past(dataRead) && !$past(ioRead) |-> readData == 8'h00)
    else $error("read data without strobe");
  a_capture_off: assert property ((!captureRouteEnable)[*3] |-> !captureInput)
    else $error("capture driven while unrouted");
  a_power_write: assert property ($rose(comparatorPowerOff) |->
    $past(dataWrite) || $past(ioWrite) || $past(dataWrite, 2) || $past(ioWrite, 2))
    else $error("power off without write");
endmodule : acc_control_assertions
bind acc_control acc_control_assertions u_chk (.*);

// ---- analog_comparator_control_tb.sv ----
// register-level testbench for the comparator control block
`timescale 1ns/10ps
module analog_comparator_control_tb;
  logic clock = 1'b0, rst_n = 1'b0, dataWrite = 1'b0, dataRead = 1'b0, ioWrite = 1'b0, ioRead = 1'b0;
  logic [7:0] dataAddr = 8'h00, dataWdata = 8'h00, ioWdata = 8'h00, srcF = 8'h00, trigCount = 8'h00, n0;
  logic [5:0] ioAddr = 6'h00;
  logic converterEnable = 1'b0, autoTriggerEnable = 1'b0, globalIrqEnable = 1'b0, vectorTaken = 1'b0;
  logic conversionDoneFlag = 1'b0, positivePinRaw = 1'b0, negativePinRaw = 1'b0;
  logic [2:0] channelSelect = 3'h0;
  logic [3:0] posLevel = 4'h2;
  wire extInt0Flag = srcF[2], t0CompareAFlag = srcF[3], t0OverflowFlag = srcF[4];
  wire t1CompareBFlag = srcF[5], t1OverflowFlag = srcF[6], t1CaptureFlag = srcF[7];
  logic [7:0] readData;
  logic [2:0] negativeMuxChannel;
  logic compareRaw, compareIrq, comparatorPowerOff, bandgapPositiveSelect, negativeFromMux, captureInput;
  logic captureRouteEnable, autoTriggerStart, positivePinBufferOn, negativePinBufferOn;
  logic positivePinRead, negativePinRead;
  int bad_count = 0, comparisons = 0;
  acc_control dut (.*);
  acc_analog_model u_ana (.comparatorPowerOff(comparatorPowerOff), .bandgapPositiveSelect(bandgapPositiveSelect),
    .negativeFromMux(negativeFromMux), .posLevel(posLevel), .negLevel(4'h4), .muxLevel(4'h4), .compareRaw(compareRaw));
  always #10 clock = ~clock;
  always @(posedge clock) if (autoTriggerStart === 1'b1) trigCount <= trigCount + 8'h01;
  task stop_test;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task gap(input int n);
    repeat (n) @(posedge clock);
  endtask : gap
  task wr(input logic [7:0] a, input logic [7:0] d, input bit io = 1'b0);
    @(posedge clock);
    dataAddr <= a; ioAddr <= a[5:0]; dataWdata <= d; ioWdata <= d; dataWrite <= !io; ioWrite <= io;
    @(posedge clock);
    dataWrite <= 1'b0; ioWrite <= 1'b0;
  endtask : wr
  task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input bit io = 1'b0);
    @(posedge clock);
    dataAddr <= a; ioAddr <= a[5:0]; dataRead <= !io; ioRead <= io;
    @(posedge clock);
    dataRead <= 1'b0; ioRead <= 1'b0;
    @(negedge clock);
    chk(readData & m, e);
    // hand back on a rising edge so later stimulus stays edge aligned
    @(posedge clock);
  endtask : rc
  task wirq;
    int i;
    comparisons++;
    for (i = 0; i < 10 && compareIrq !== 1'b1; i++) @(posedge clock);
    if (i == 10) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, compareIrq, 1'b1);
      stop_test();
    end
  endtask : wirq
  initial begin
    gap(20000);
    bad_count++;
    $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  end
  initial begin
    gap(6);
    rst_n <= 1'b1;
    rc(8'h7B, 8'hFF, 8'h00);
    rc(8'h7F, 8'hFF, 8'h00);
    rc(8'h50, 8'hFF, 8'h00);
    rc(8'h60, 8'hFF, 8'h00);
    chk({negativePinBufferOn, negativePinRead, positivePinBufferOn, positivePinRead, compareIrq, captureRouteEnable, comparatorPowerOff, negativeFromMux}, 8'hA0);
    wr(8'h7B, 8'hFF);
    rc(8'h7B, 8'hFF, 8'h47);
    for (int c = 0; c < 8; c++) begin
      channelSelect <= 3'(c);
      gap(3);
      chk({4'h0, negativeFromMux, negativeMuxChannel}, 8'h08 | 8'(c));
    end
    $display("registers and mux done");
    wr(8'h30, 8'hFF, 1'b1);
    rc(8'h30, 8'hFF, 8'hCF, 1'b1);
    chk({6'h00, comparatorPowerOff, bandgapPositiveSelect}, 8'h03);
    wr(8'h30, 8'hC7, 1'b1);
    // enable stays low across every mode change
    for (int k = 0; k < 4; k++) begin
      wr(8'h50, 8'h10 | 8'(k));
      posLevel <= 4'h8;
      gap(6);
      rc(8'h50, 8'h30, (k == 0 || k == 3) ? 8'h30 : 8'h20);
      wr(8'h50, 8'h10 | 8'(k));
      posLevel <= 4'h2;
      gap(6);
      rc(8'h50, 8'h30, (k == 0 || k == 2) ? 8'h10 : 8'h00);
    end
    $display("event modes done");
    globalIrqEnable <= 1'b1;
    wr(8'h50, 8'h1B);
    posLevel <= 4'h8;
    wirq();
    vectorTaken <= 1'b1;
    @(posedge clock) vectorTaken <= 1'b0;
    gap(3);
    chk({7'h00, compareIrq}, 8'h00);
    posLevel <= 4'h2;
    globalIrqEnable <= 1'b0;
    gap(4);
    posLevel <= 4'h8;
    gap(6);
    chk({7'h00, compareIrq}, 8'h00);
    rc(8'h50, 8'h10, 8'h10);
    wr(8'h50, 8'h1B);
    globalIrqEnable <= 1'b1;
    gap(3);
    chk({7'h00, compareIrq}, 8'h00);
    wr(8'h50, 8'h03);
    wr(8'h50, 8'h04);
    gap(4);
    chk({6'h00, captureRouteEnable, captureInput}, 8'h03);
    // toggles here also leave the event flag set for the comparator trigger source
    posLevel <= 4'h2;
    gap(5);
    chk({6'h00, captureRouteEnable, captureInput}, 8'h02);
    posLevel <= 4'h8;
    gap(5);
    wr(8'h50, 8'h00);
    gap(4);
    chk({6'h00, captureRouteEnable, captureInput}, 8'h00);
    $display("interrupt and capture done");
    converterEnable <= 1'b1;
    autoTriggerEnable <= 1'b1;
    conversionDoneFlag <= 1'b1;
    wr(8'h7B, 8'h40);
    gap(3);
    chk({7'h00, negativeFromMux}, 8'h00);
    for (int s = 1; s < 8; s++) begin
      srcF[s] <= 1'b1;
      gap(2);
      n0 = trigCount;
      wr(8'h7B, 8'(s));
      gap(6);
      chk(trigCount - n0, 8'h01);
      wr(8'h7B, 8'h00);
      gap(4);
      chk(trigCount - n0, 8'h01);
      srcF[s] <= 1'b0;
    end
    autoTriggerEnable <= 1'b0;
    srcF[7] <= 1'b1;
    n0 = trigCount;
    wr(8'h7B, 8'h07);
    gap(6);
    chk(trigCount - n0, 8'h00);
    $display("auto trigger done");
    positivePinRaw <= 1'b1;
    negativePinRaw <= 1'b1;
    wr(8'h7F, 8'hFF);
    rc(8'h7F, 8'hFF, 8'h03);
    chk({4'h0, negativePinBufferOn, negativePinRead, positivePinBufferOn, positivePinRead}, 8'h00);
    wr(8'h7F, 8'h01);
    gap(3);
    chk({4'h0, negativePinBufferOn, negativePinRead, positivePinBufferOn, positivePinRead}, 8'h0C);
    wr(8'h7F, 8'h00);
    gap(3);
    chk({4'h0, negativePinBufferOn, negativePinRead, positivePinBufferOn, positivePinRead}, 8'h0F);
    $display("pin disable done");
    stop_test();
  end
endmodule : analog_comparator_control_tb
